/* logic/pmg_guard.sv */
// How it works
// [R1] read-protect blocks all external accesses
// [R2] write-protect low blocks internal writes, erases
// [R3] segment hit drops the safety interlock
// [R4] segment protection only adds protection
// [R5] segment disable low enables segment protection
// [R6] selected 512-word page always protected
// [R7] bottom boundary: zero through selected page
// [R8] top boundary: selected page through end
// [R9] last page protect adds configuration page
// [R10] complementary shadow compared every cycle
// [R11] shadow mismatch forces a device reset
// [R12] configuration loaded from stored configuration words
// [R13] refused request flagged, memory untouched
`timescale 1ns/100ps
`include "pmg_regs.svh"
module pmg_guard
	import pmg_pkg::*;
(
	input  wire logic                   i_clk,
	input  wire logic                   i_resetn,
	input  wire logic                   i_cfg_load,
	input  wire logic [`PMG_CFG_W-1:0]  i_cfg_word,
	input  wire logic                   i_req_valid,
	input  wire logic                   i_req_external,
	input  wire logic                   i_req_write,
	input  wire logic [`PMG_ADDR_W-1:0] i_req_addr,
	output logic                        o_grant,
	output logic                        o_refuse,
	output logic                        o_interlock_en,
	output logic                        o_cfg_valid,
	output logic                        o_device_reset
);
	pmg_cfg_t   cfg_q;
	pmg_cfg_t   shadow_q;
	pmg_state_t state_q;
	pmg_state_t state_d;
	logic       grant_q;
	logic       refuse_q;
	logic       ilock_q;
	logic       rst_q;
	logic       cfg_valid_q;

	function automatic pmg_cfg_t unpack_cfg(input logic [`PMG_CFG_W-1:0] w);
		pmg_cfg_t c;
		c.general_read_protect    = w[`PMG_B_RDPROT];
		c.general_write_protect   = w[`PMG_B_WRPROT];
		c.segment_protect_disable = w[`PMG_B_SEGDIS];
		c.segment_boundary_select = w[`PMG_B_BOUND];
		c.last_page_protect       = w[`PMG_B_LASTPG];
		c.segment_page_select     = w[`PMG_B_PAGE_HI:0];
		return c;
	endfunction

	wire pmg_req_t req = '{valid: i_req_valid, external: i_req_external,
		is_write: i_req_write, addr: i_req_addr};
	wire logic [`PMG_PAGE_W-1:0] page = req.addr[`PMG_PAGE_SHIFT +: `PMG_PAGE_W];
	wire logic active = (state_q == PMG_ACTIVE);

	// [R10] shadow comparison
	wire logic mismatch = active && ((cfg_q ^ shadow_q) != '1);

	// [R5] segment enable
	wire logic seg_en = (cfg_q.segment_protect_disable == `PMG_PROG);
	// [R7] bottom range includes page
	wire logic in_low = (page <= cfg_q.segment_page_select);
	// [R8] top range includes page
	wire logic in_high = (page >= cfg_q.segment_page_select);
	// [R9] configuration page
	wire logic in_last = (cfg_q.last_page_protect == `PMG_PROG) && (page == `PMG_LAST_PAGE);
	// [R6] page itself inclusive in both
	wire logic seg_hit = seg_en && (cfg_q.segment_boundary_select ? in_high
		: (in_low || in_last));

	// [R1] external block
	wire logic ext_block = req.external && (cfg_q.general_read_protect == `PMG_PROG);
	// [R2] internal write block
	wire logic gen_wr_block = !req.external && req.is_write
		&& (cfg_q.general_write_protect == `PMG_PROG);
	// [R3] segment blocks writes only
	wire logic seg_block = req.is_write && seg_hit;
	// [R4] protections combine by or
	wire logic blocked = !active || ext_block || gen_wr_block || seg_block;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PMG_EMPTY:  if (i_cfg_load) state_d = PMG_ACTIVE;
			PMG_ACTIVE: if (mismatch) state_d = PMG_FAULT;
			PMG_FAULT:  state_d = PMG_FAULT;
			// a corrupted state code is treated as a fault
			default:    state_d = PMG_FAULT;
		endcase
	end

	// [R12] load from stored words
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			// erased value: every field high, shadow its inverse
			cfg_q    <= '1;
			shadow_q <= '0;
		end else if (i_cfg_load && state_q == PMG_EMPTY) begin
			cfg_q    <= unpack_cfg(i_cfg_word);
			shadow_q <= ~unpack_cfg(i_cfg_word);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q  <= PMG_EMPTY;
			grant_q  <= 1'b0;
			refuse_q <= 1'b0;
			ilock_q  <= 1'b0;
			rst_q    <= 1'b0;
			cfg_valid_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			// [R13] per-request refusal
			grant_q  <= req.valid && !blocked;
			refuse_q <= req.valid && blocked;
			// [R3] interlock dropped on refusal
			ilock_q  <= req.valid && req.is_write && !blocked;
			// [R11] parity error resets device
			rst_q    <= (state_d == PMG_FAULT);
			// [R12] loaded and healthy
			cfg_valid_q <= (state_d == PMG_ACTIVE);
		end
	end

	assign o_grant        = grant_q;
	assign o_refuse       = refuse_q;
	assign o_interlock_en = ilock_q;
	assign o_cfg_valid    = cfg_valid_q;
	assign o_device_reset = rst_q;

	default clocking cb @(posedge i_clk); endclocking
	// no checking while i_resetn holds the flops in reset
	default disable iff (!i_resetn);

	// [R1] external access blocked
	property p_ext_read_block;
		req.valid && req.external && active && cfg_q.general_read_protect == `PMG_PROG
			|=> o_refuse && !o_grant;
	endproperty
	a_ext_read_block: assert property (p_ext_read_block) // [R1]
		else $error("external access granted");

	// [R2] internal write blocked
	property p_int_write_block;
		req.valid && !req.external && req.is_write && cfg_q.general_write_protect == 1'b0
			|=> o_refuse && !o_interlock_en;
	endproperty
	a_int_write_block: assert property (p_int_write_block) // [R2]
		else $error("write not blocked");

	// [R1] internal reads unaffected
	property p_int_read_ok;
		req.valid && !req.external && !req.is_write && active |=> o_grant;
	endproperty
	a_int_read_ok: assert property (p_int_read_ok) // [R1]
		else $error("internal read refused");

	// [R3] segment hit refused
	property p_seg_hit;
		req.valid && req.is_write && seg_hit |=> !o_interlock_en && o_refuse;
	endproperty
	a_seg_hit: assert property (p_seg_hit) // [R3]
		else $error("segment write allowed");

	// [R5] disabled segment adds nothing
	property p_seg_off;
		req.valid && !req.external && req.is_write && active && cfg_q.segment_protect_disable
			&& cfg_q.general_write_protect |=> o_grant && o_interlock_en;
	endproperty
	a_seg_off: assert property (p_seg_off) // [R5]
		else $error("disabled segment blocked");

	// [R7] bottom range refused
	property p_bottom;
		req.valid && req.is_write && active && !cfg_q.segment_protect_disable
			&& !cfg_q.segment_boundary_select && page <= cfg_q.segment_page_select |=> o_refuse;
	endproperty
	a_bottom: assert property (p_bottom) // [R7]
		else $error("bottom range write allowed");

	// [R8] top range refused
	property p_top;
		req.valid && req.is_write && active && !cfg_q.segment_protect_disable
			&& cfg_q.segment_boundary_select && page >= cfg_q.segment_page_select |=> o_refuse;
	endproperty
	a_top: assert property (p_top) // [R8]
		else $error("top range write allowed");

	// [R11] parity error resets device
	property p_fault;
		active && mismatch |=> o_device_reset ##1 o_device_reset;
	endproperty
	a_fault: assert property (p_fault) // [R11]
		else $error("parity error missed");

	// [R13] one answer only
	property p_onehot;
		!(o_grant && o_refuse);
	endproperty
	a_onehot: assert property (p_onehot) // [R13]
		else $error("grant and refuse together");

	// [R1] external read allowed when open
	property p_ext_read_ok;
		req.valid && req.external && !req.is_write && active
			&& cfg_q.general_read_protect != `PMG_PROG |=> o_grant && !o_refuse;
	endproperty
	a_ext_read_ok: assert property (p_ext_read_ok) // [R1]
		else $error("open external read refused");

	// [R2] internal write allowed when open
	property p_int_write_ok;
		req.valid && !req.external && req.is_write && active && !seg_hit
			&& cfg_q.general_write_protect != `PMG_PROG |=> o_grant && o_interlock_en;
	endproperty
	a_int_write_ok: assert property (p_int_write_ok) // [R2]
		else $error("open internal write refused");

	// [R3] interlock only with grant
	property p_ilock_grant;
		o_interlock_en |-> o_grant;
	endproperty
	a_ilock_grant: assert property (p_ilock_grant) // [R3]
		else $error("interlock without grant");

	// [R4] general guard outside segment
	property p_outside_general;
		req.valid && !req.external && req.is_write && active && !seg_hit
			&& cfg_q.general_write_protect == `PMG_PROG |=> o_refuse;
	endproperty
	a_outside_general: assert property (p_outside_general) // [R4]
		else $error("general guard lost outside segment");

	// [R6] selected page inclusive
	property p_page_inclusive;
		req.valid && req.is_write && active && seg_en
			&& page == cfg_q.segment_page_select |=> o_refuse && !o_interlock_en;
	endproperty
	a_page_inclusive: assert property (p_page_inclusive) // [R6]
		else $error("selected page write allowed");

	// [R9] configuration page guarded
	property p_last_page;
		req.valid && req.is_write && active && seg_en && !cfg_q.segment_boundary_select
			&& cfg_q.last_page_protect == `PMG_PROG && page == `PMG_LAST_PAGE |=> o_refuse;
	endproperty
	a_last_page: assert property (p_last_page) // [R9]
		else $error("last page write allowed");

	// [R7] above bottom range open
	property p_bottom_open;
		req.valid && !req.external && req.is_write && active && seg_en
			&& cfg_q.general_write_protect != `PMG_PROG && !cfg_q.segment_boundary_select
			&& page > cfg_q.segment_page_select && page != `PMG_LAST_PAGE |=> o_grant;
	endproperty
	a_bottom_open: assert property (p_bottom_open) // [R7]
		else $error("write above bottom range refused");

	// [R8] below top range open
	property p_top_open;
		req.valid && !req.external && req.is_write && active && seg_en
			&& cfg_q.general_write_protect != `PMG_PROG && cfg_q.segment_boundary_select
			&& page < cfg_q.segment_page_select |=> o_grant;
	endproperty
	a_top_open: assert property (p_top_open) // [R8]
		else $error("write below top range refused");

	// [R11] device reset sticky
	property p_fault_sticky;
		o_device_reset |=> o_device_reset;
	endproperty
	a_fault_sticky: assert property (p_fault_sticky) // [R11]
		else $error("device reset dropped");

	// [R11] nothing granted after fault
	property p_fault_refuse;
		o_device_reset && req.valid |=> o_refuse && !o_grant;
	endproperty
	a_fault_refuse: assert property (p_fault_refuse) // [R11]
		else $error("request granted after fault");

	// [R11] fault clears valid
	property p_fault_invalid;
		mismatch |=> !o_cfg_valid;
	endproperty
	a_fault_invalid: assert property (p_fault_invalid) // [R11]
		else $error("configuration valid after fault");

	// [R12] nothing before load
	property p_not_loaded;
		req.valid && !active |=> o_refuse && !o_interlock_en;
	endproperty
	a_not_loaded: assert property (p_not_loaded) // [R12]
		else $error("request granted before load");

	// [R12] first load takes effect
	property p_load;
		i_cfg_load && state_q == PMG_EMPTY |=> o_cfg_valid;
	endproperty
	a_load: assert property (p_load) // [R12]
		else $error("configuration not loaded");

	// [R13] every request answered
	property p_answer;
		req.valid |=> o_grant != o_refuse;
	endproperty
	a_answer: assert property (p_answer) // [R13]
		else $error("request not answered");

	// [R13] no answer without request
	property p_quiet;
		!req.valid |=> !o_grant && !o_refuse && !o_interlock_en;
	endproperty
	a_quiet: assert property (p_quiet) // [R13]
		else $error("answer without request");

	// main scenarios
	c_grant: cover property (req.valid && active ##1 o_grant);
	c_seg: cover property (seg_block && req.valid ##1 o_refuse);
	c_fault: cover property (o_device_reset);
	c_ext_block: cover property (req.valid && ext_block ##1 o_refuse);
	c_top: cover property (req.valid && seg_block && cfg_q.segment_boundary_select ##1 o_refuse);
endmodule // pmg_guard

/* logic/pmg_pkg.sv */
package pmg_pkg;
	typedef struct packed {
		logic       valid;
		logic       external;
		logic       is_write;
		logic [23:0] addr;
	} pmg_req_t;
	typedef struct packed {
		logic general_read_protect;
		logic general_write_protect;
		logic segment_protect_disable;
		logic segment_boundary_select;
		logic last_page_protect;
		logic [6:0] segment_page_select;
	} pmg_cfg_t;
	typedef enum logic [1:0] {
		PMG_EMPTY,
		PMG_ACTIVE,
		PMG_FAULT
	} pmg_state_t;
endpackage

/* logic/pmg_regs.svh */
`ifndef PMG_REGS_SVH
`define PMG_REGS_SVH
// program memory geometry (word addresses)
`define PMG_ADDR_W      24
`define PMG_PAGE_SHIFT  9
`define PMG_PAGE_W      7
`define PMG_LAST_PAGE   7'h7f
`define PMG_ADDR_ZERO   24'h000000
// configuration word field positions
`define PMG_CFG_W       11
`define PMG_B_RDPROT    10
`define PMG_B_WRPROT    9
`define PMG_B_SEGDIS    8
`define PMG_B_BOUND     7
`define PMG_B_LASTPG    6
`define PMG_B_PAGE_HI   6
// erased (unprogrammed) configuration value: every bit high
`define PMG_CFG_RESET   11'h7ff
// active levels: programmed bits read low
`define PMG_PROG        1'b0
`endif

/* sim/pmg_nvm_model.sv */
`timescale 1ns/100ps
module pmg_nvm_model
	import pmg_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_interlock_en,
	output pmg_req_t  o_req
);
	int writes = 0;
	initial o_req = '0;
	always @(posedge i_clk)
		if (i_interlock_en)
			writes <= writes + 1;
	task automatic issue(input logic e, input logic w, input logic [15:0] a);
		@(posedge i_clk);
		o_req <= '{1'b1, e, w, {8'h00, a}};
		@(posedge i_clk);
		// idle lines show the inverse, not stale values
		o_req <= '{1'b0, ~e, ~w, {8'hff, ~a}};
	endtask
endmodule // pmg_nvm_model

/* sim/program_memory_write_guard_tb.sv */
`timescale 1ns/100ps
module program_memory_write_guard_tb;
	import pmg_pkg::*;
	logic        clk;
	logic        resetn;
	logic        cfg_load;
	logic [10:0] cfg_word;
	pmg_req_t    req;
	logic        grant;
	logic        refuse;
	logic        lock;
	logic        cfg_ok;
	logic        dev_rst;
	int          bad_count = 0;
	int          comparisons = 0;
	int          expected = 0;
	pmg_guard i_pmg_guard (.i_clk(clk), .i_resetn(resetn), .i_cfg_load(cfg_load),
		.i_cfg_word(cfg_word), .i_req_valid(req.valid), .i_req_external(req.external),
		.i_req_write(req.is_write), .i_req_addr(req.addr), .o_grant(grant),
		.o_refuse(refuse), .o_interlock_en(lock), .o_cfg_valid(cfg_ok),
		.o_device_reset(dev_rst));
	pmg_nvm_model i_pmg_nvm_model (.i_clk(clk), .i_interlock_en(lock), .o_req(req));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic check(input logic [2:0] seen, input logic [2:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %b want %b", $time, seen, exp);
		end
	endtask
	// expectation {grant, refuse, interlock}
	task automatic acc(input logic e, input logic w, input logic [15:0] a, input logic [2:0] x);
		i_pmg_nvm_model.issue(e, w, a);
		#1;
		expected += x[0];
		check({grant, refuse, lock}, x);
	endtask
	task automatic setup(input logic [10:0] c);
		@(posedge clk);
		resetn <= 1'b0;
		cfg_word <= c;
		repeat (4) @(posedge clk);
		check({cfg_ok, dev_rst, grant}, 3'b000); // cleared in reset
		resetn <= 1'b1;
		acc(1'b0, 1'b0, 16'h0000, 3'b010); // refused before load
		@(posedge clk);
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		#1;
		check({cfg_ok, dev_rst, 1'b0}, 3'b100); // healthy after load
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		resetn = 1'b1;
		cfg_load = 1'b0;
		cfg_word = 11'h7ff;
		setup(11'h7ff);
		acc(1'b1, 1'b1, 16'hffff, 3'b101); // no added guard
		acc(1'b0, 1'b1, 16'h0000, 3'b101); // no added guard
		setup(11'h3ff);
		acc(1'b1, 1'b0, 16'h0000, 3'b010); // external read blocked
		acc(1'b0, 1'b0, 16'h0000, 3'b100); // internal unaffected
		setup(11'h5ff);
		acc(1'b0, 1'b1, 16'h1234, 3'b010); // write blocked
		acc(1'b0, 1'b0, 16'h1234, 3'b100); // read allowed
		setup(11'h640);
		acc(1'b0, 1'b1, 16'h0000, 3'b010); // bottom word guarded
		acc(1'b0, 1'b1, 16'h81ff, 3'b010); // selected page guarded
		acc(1'b0, 1'b1, 16'h8200, 3'b101); // next page open
		acc(1'b0, 1'b0, 16'h81ff, 3'b100); // reads pass
		acc(1'b0, 1'b1, 16'hffff, 3'b101); // last page open
		setup(11'h63f);
		acc(1'b0, 1'b1, 16'h7fff, 3'b010); // page end guarded
		acc(1'b0, 1'b1, 16'h8000, 3'b101); // above page open
		acc(1'b0, 1'b1, 16'hfe00, 3'b010); // last page guarded
		setup(11'h690);
		acc(1'b0, 1'b1, 16'h1fff, 3'b101); // below page open
		acc(1'b0, 1'b1, 16'h2000, 3'b010); // page start guarded
		acc(1'b0, 1'b1, 16'hffff, 3'b010); // end guarded
		setup(11'h440);
		acc(1'b0, 1'b1, 16'h8200, 3'b010); // general still applies
		@(posedge clk);
		cfg_word <= 11'h7ff;
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		acc(1'b0, 1'b1, 16'h8200, 3'b010); // second load ignored
		@(posedge clk);
		#1;
		check(3'(i_pmg_nvm_model.writes), 3'(expected)); // refused writes absent
		report_and_stop();
	end
endmodule // program_memory_write_guard_tb
